/* File: shared/sp_pkg.sv */
// Shared constants and types for set-point switching and write leveling
`default_nettype none

package sp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SWITCH_SINGLE_NS = 200;
    localparam int SWITCH_MULTI_NS  = 200;
    localparam int SWITCH_RANGE_NS  = 250;
    localparam int TIMER_W          = 8;

    // Least times round up to whole cycles
    localparam logic [TIMER_W-1:0] SINGLE_CYC =
        TIMER_W'((SWITCH_SINGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] MULTI_CYC  =
        TIMER_W'((SWITCH_MULTI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] RANGE_CYC  =
        TIMER_W'((SWITCH_RANGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int OP_SELECT_BIT  = 7;   // point control: operating set
    localparam int ACC_SELECT_BIT = 6;   // point control: access set
    localparam int REF_CUR_BIT    = 3;   // point control: fast reference current
    localparam int WL_BIT         = 7;   // latency register: write leveling
    localparam int RANGE_BIT      = 6;   // command reference: range
    localparam int SETTING_MSB    = 5;   // command reference: setting
    localparam int BYTE_W         = 8;
    localparam logic [6:0] CMD_REF_RESET = 7'h4D;
    localparam logic [6:0] LATENCY_RESET = 7'h00;
    localparam logic [5:0] MULTI_STEP    = 6'h02;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        REG_POINT_CONTROL,
        REG_COMMAND_REFERENCE,
        REG_LATENCY,
        REG_OTHER
    } reg_sel_t;

    typedef enum logic [1:0] {
        CLASS_NONE,
        CLASS_SINGLE,
        CLASS_MULTI,
        CLASS_RANGE
    } switch_class_t;

    typedef enum logic {
        SW_IDLE,
        SW_WAIT
    } sw_state_t;

    typedef struct packed {
        logic       valid;
        reg_sel_t   sel;
        logic [7:0] data;
    } mrw_t;

endpackage : sp_pkg

`default_nettype wire

/* File: rtl/wl_capture.sv */
// Strobe-clocked clock-level capture with crossing into the core clock
`timescale 1ns/1ps
`default_nettype none

module wl_capture (
    // Strobe side
    input  wire logic strobe_clk,
    input  wire logic ck_level,
    // Core side
    input  wire logic ref_clk,
    input  wire logic rstn,
    output logic      level_sync
);

    typedef struct packed {
        logic cap;
    } link_st_t;

    typedef struct packed {
        logic [1:0] sync;
    } core_st_t;

    link_st_t lq, ld;
    core_st_t cq, cd;

    // ************************************************************
    // Strobe domain
    // ************************************************************
    // Every rising strobe edge overwrites the held level; the strobe stops
    // between bursts, so no reset can be relied on here
    always_comb begin
        ld     = lq;
        ld.cap = ck_level;
    end

    always_ff @(posedge strobe_clk) begin
        lq <= ld;
    end

    // ************************************************************
    // Core domain: two-flop synchroniser of a single level
    // ************************************************************
    always_comb begin
        cd      = cq;
        cd.sync = {cq.sync[0], lq.cap};
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    assign level_sync = cq.sync[1];

endmodule : wl_capture

`default_nettype wire

/* File: rtl/set_point_switch_and_write_leveling.sv */
// Set-point switching timer, duplicated parameter sets and write leveling
`timescale 1ns/1ps
`default_nettype none

module set_point_switch_and_write_leveling #(
    parameter logic [6:0] CMD_REF_DEFAULT = sp_pkg::CMD_REF_RESET,
    parameter logic [6:0] LATENCY_DEFAULT = sp_pkg::LATENCY_RESET
) (
    // Core clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Decoded mode register writes
    input  wire sp_pkg::mrw_t          mrw,
    // Link: strobe clocks and clock level
    input  wire logic                  dqs0_clk,
    input  wire logic                  dqs1_clk,
    input  wire logic                  ck_level,
    // Data pins, output side
    output logic [15:0]                dq_out,
    output logic [15:0]                dq_oe,
    // Status
    output logic                       operating_point_select,
    output logic                       point_access_select,
    output logic                       reference_current_mode,
    output logic                       active_point,
    output logic                       switch_busy,
    output sp_pkg::switch_class_t      switch_class,
    output logic [6:0]                 active_cmd_ref,
    output logic [6:0]                 active_latency,
    output logic                       wl_active
);

    typedef struct packed {
        logic                         op_req;
        logic                         op_act;
        logic                         acc;
        logic                         rcm;
        logic                         wl;
        logic [1:0][6:0]              cref;
        logic [1:0][6:0]              lat;
        sp_pkg::sw_state_t            sw;
        sp_pkg::switch_class_t        cls;
        logic [sp_pkg::TIMER_W-1:0]   cnt;
        logic [15:0]                  dq;
        logic [15:0]                  oe;
    } st_t;

    st_t  q, d;
    logic lvl0, lvl1;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Class depends only on the range bits and setting distance of the sets, so either
    // direction of switch gets the same time
    function automatic sp_pkg::switch_class_t classify(input logic [6:0] a,
                                                       input logic [6:0] b);
        logic [5:0] diff;
        diff = (a[sp_pkg::SETTING_MSB:0] > b[sp_pkg::SETTING_MSB:0])
             ? a[sp_pkg::SETTING_MSB:0] - b[sp_pkg::SETTING_MSB:0]
             : b[sp_pkg::SETTING_MSB:0] - a[sp_pkg::SETTING_MSB:0];
        if (a[sp_pkg::RANGE_BIT] != b[sp_pkg::RANGE_BIT]) begin
            return sp_pkg::CLASS_RANGE;
        end else if (diff >= sp_pkg::MULTI_STEP) begin
            return sp_pkg::CLASS_MULTI;
        end
        return sp_pkg::CLASS_SINGLE;
    endfunction : classify

    function automatic logic [sp_pkg::TIMER_W-1:0] switch_cycles(
        input sp_pkg::switch_class_t c);
        case (c)
            sp_pkg::CLASS_RANGE: return sp_pkg::RANGE_CYC;
            sp_pkg::CLASS_MULTI: return sp_pkg::MULTI_CYC;
            default:             return sp_pkg::SINGLE_CYC;
        endcase
    endfunction : switch_cycles

    // Timer must hold the longest switch count without wrapping
    if ((sp_pkg::SWITCH_RANGE_NS + sp_pkg::CLK_PERIOD_NS - 1) / sp_pkg::CLK_PERIOD_NS
        >= (1 << sp_pkg::TIMER_W)) begin : g_timer_check
        $error("switch timer too narrow for the range-change time");
    end

    // ************************************************************
    // Strobe captures, one per byte lane
    // ************************************************************
    wl_capture u_cap0 (
        .strobe_clk (dqs0_clk),
        .ck_level   (ck_level),
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .level_sync (lvl0)
    );

    wl_capture u_cap1 (
        .strobe_clk (dqs1_clk),
        .ck_level   (ck_level),
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .level_sync (lvl1)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;
        // Switch timer; the new set takes over only once the time is spent
        if (q.sw == sp_pkg::SW_WAIT) begin
            if (q.cnt <= 1) begin
                d.sw     = sp_pkg::SW_IDLE;
                d.op_act = q.op_req;
                d.cnt    = '0;
            end else begin
                d.cnt = q.cnt - 1'b1;
            end
        end
        // Mode register writes; writes to duplicated fields go to the
        // set chosen by the access bit, not the active one
        if (mrw.valid) begin
            if (mrw.sel == sp_pkg::REG_POINT_CONTROL) begin
                d.acc = mrw.data[sp_pkg::ACC_SELECT_BIT];
                d.rcm = mrw.data[sp_pkg::REF_CUR_BIT];
                // A change requested mid-switch is dropped: the bus is
                // expected to carry only deselects then
                if (q.sw == sp_pkg::SW_IDLE &&
                    mrw.data[sp_pkg::OP_SELECT_BIT] != q.op_req) begin
                    d.op_req = mrw.data[sp_pkg::OP_SELECT_BIT];
                    d.cls    = classify(q.cref[0], q.cref[1]);
                    d.cnt    = switch_cycles(d.cls);
                    d.sw     = sp_pkg::SW_WAIT;
                end
            end else if (mrw.sel == sp_pkg::REG_COMMAND_REFERENCE) begin
                d.cref[q.acc] = mrw.data[6:0];
            end else if (mrw.sel == sp_pkg::REG_LATENCY) begin
                d.lat[q.acc] = mrw.data[6:0];
                d.wl         = mrw.data[sp_pkg::WL_BIT];
            end
        end
        // Leveling feedback: each lane repeats its own strobe's sample
        if (q.wl) begin
            d.dq = {{sp_pkg::BYTE_W{lvl1}}, {sp_pkg::BYTE_W{lvl0}}};
            d.oe = '1;
        end else begin
            d.dq = '0;
            d.oe = '0;
        end
    end

    // Power-up on set zero with both sets at defaults
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            q      <= '0;
            q.cref <= {2{CMD_REF_DEFAULT}};
            q.lat  <= {2{LATENCY_DEFAULT}};
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign dq_out                 = q.dq;
    assign dq_oe                  = q.oe;
    assign operating_point_select = q.op_req;
    assign point_access_select    = q.acc;
    assign reference_current_mode = q.rcm;
    assign active_point           = q.op_act;
    assign switch_busy            = (q.sw == sp_pkg::SW_WAIT);
    assign switch_class           = q.cls;
    assign active_cmd_ref         = q.cref[q.op_act];
    assign active_latency         = q.lat[q.op_act];
    assign wl_active              = q.wl;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [sp_pkg::TIMER_W-1:0] busy_len_q;

    // Length of the last busy stretch, read when busy falls
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            busy_len_q <= '0;
        end else if (switch_busy) begin
            busy_len_q <= busy_len_q + 1'b1;
        end else begin
            busy_len_q <= '0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence wl_held;
        wl_active ##1 wl_active;
    endsequence

    single_time_a: assert property (
        $fell(switch_busy) && switch_class == sp_pkg::CLASS_SINGLE
        |-> busy_len_q == sp_pkg::SINGLE_CYC)
        else $error("single-step switch time wrong");

    multi_time_a: assert property (
        $fell(switch_busy) && switch_class == sp_pkg::CLASS_MULTI
        |-> busy_len_q == sp_pkg::MULTI_CYC)
        else $error("multi-step switch time wrong");

    range_time_a: assert property (
        $fell(switch_busy) && switch_class == sp_pkg::CLASS_RANGE
        |-> busy_len_q == sp_pkg::RANGE_CYC)
        else $error("range-change switch time wrong");

    class_symmetry_a: assert property (
        $rose(switch_busy) |-> switch_class == classify(q.cref[1], q.cref[0]))
        else $error("switch class depends on direction");

    reset_point_a: assert property (
        $rose(rstn) |-> !active_point && !operating_point_select && !wl_active)
        else $error("not on set zero after reset");

    active_set_a: assert property (
        !switch_busy |-> active_point == operating_point_select)
        else $error("active set differs from operating select when idle");

    wl_entry_a: assert property (
        mrw.valid && mrw.sel == sp_pkg::REG_LATENCY && mrw.data[sp_pkg::WL_BIT]
        |=> wl_active ##1 dq_oe == 16'hFFFF)
        else $error("write leveling entry failed");

    wl_exit_a: assert property (
        !wl_active |=> dq_oe == 16'h0000)
        else $error("data pins driven outside leveling");

    byte0_level_a: assert property (
        wl_active |=> dq_out[7:0] == {8{$past(lvl0)}})
        else $error("lower lane does not follow strobe zero");

    byte1_level_a: assert property (
        wl_held |-> dq_out[15:8] == {8{$past(lvl1)}})
        else $error("upper lane does not follow strobe one");

endmodule : set_point_switch_and_write_leveling

`default_nettype wire

/* File: dv/ctrl_model.sv */
// Controller-side model: strobe bursts and the clock level seen by the device
`timescale 1ns/1ps
`default_nettype none

module ctrl_model (
    // Burst requests from the sequence
    input  wire logic go0,
    input  wire logic go1,
    input  wire logic lvl,
    // Lines toward the device
    output logic      dqs0_clk,
    output logic      dqs1_clk,
    output logic      ck_level
);
    // ************************************************************
    // Strobe bursts
    // ************************************************************
    // Clock level held by the sequence across each whole burst
    assign ck_level = lvl;
    // Strobes parked low between bursts, so no stray edge is captured; two full
    // pulses per burst since the first edge may be lost; odd offset keeps phase unrelated
    initial begin
        dqs0_clk = 1'b0;
        forever begin
            @(posedge go0);
            repeat (2) begin
                #83 dqs0_clk = 1'b1;
                #77 dqs0_clk = 1'b0;
            end
        end
    end
    // Second lane runs on its own requests, leveled apart from the first
    initial begin
        dqs1_clk = 1'b0;
        forever begin
            @(posedge go1);
            repeat (2) begin
                #83 dqs1_clk = 1'b1;
                #77 dqs1_clk = 1'b0;
            end
        end
    end
endmodule : ctrl_model

`default_nettype wire

/* File: dv/set_point_switch_and_write_leveling_tb.sv */
// Self-checking bench for set-point switching and write leveling
`timescale 1ns/1ps
`default_nettype none

module set_point_switch_and_write_leveling_tb;
    // ************************************************************
    // Signals and model state
    // ************************************************************
    logic                  ref_clk, rstn, go0, go1, lvl;
    logic                  dqs0_clk, dqs1_clk, ck_level;
    sp_pkg::mrw_t          mrw;
    logic [15:0]           dq_out, dq_oe;
    logic                  operating_point_select, point_access_select;
    logic                  reference_current_mode, active_point, switch_busy, wl_active;
    sp_pkg::switch_class_t switch_class;
    logic [6:0]            active_cmd_ref, active_latency;
    logic [6:0]            cref [2];
    logic [6:0]            lat  [2];
    logic                  op, acc;
    int                    num_errors, num_checks, cycles, seed;

    set_point_switch_and_write_leveling dut (
        .ref_clk(ref_clk), .rstn(rstn), .mrw(mrw), .dqs0_clk(dqs0_clk), .dqs1_clk(dqs1_clk),
        .ck_level(ck_level), .dq_out(dq_out), .dq_oe(dq_oe),
        .operating_point_select(operating_point_select),
        .point_access_select(point_access_select),
        .reference_current_mode(reference_current_mode), .active_point(active_point),
        .switch_busy(switch_busy), .switch_class(switch_class),
        .active_cmd_ref(active_cmd_ref), .active_latency(active_latency), .wl_active(wl_active));
    ctrl_model ctrl (
        .go0(go0), .go1(go1), .lvl(lvl),
        .dqs0_clk(dqs0_clk), .dqs1_clk(dqs1_clk), .ck_level(ck_level));

    // ************************************************************
    // Clock, timeout and helpers
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Ceiling well above the roughly 730 cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            $display("[ERR] %0t run did not finish in time", $time);
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic ok, input string what);
        num_checks++;
        if (!ok) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : chk
    // One-cycle write pulse; the model mirrors it into the set that writes reach
    task automatic mrw_wr(input sp_pkg::reg_sel_t s, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        mrw = '{valid: 1'b1, sel: s, data: d};
        @(posedge ref_clk);
        #1;
        mrw.valid = 1'b0;
        if (s == sp_pkg::REG_COMMAND_REFERENCE) cref[acc] = d[6:0];
        if (s == sp_pkg::REG_LATENCY) lat[acc] = d[6:0];
    endtask : mrw_wr
    task automatic pc_wr(input logic o, input logic a, input logic f);
        logic [7:0] d;
        d = 8'h00;
        d[sp_pkg::OP_SELECT_BIT] = o;
        d[sp_pkg::ACC_SELECT_BIT] = a;
        d[sp_pkg::REF_CUR_BIT] = f;
        mrw_wr(sp_pkg::REG_POINT_CONTROL, d);
        acc = a;
    endtask : pc_wr
    // Switch class from the two stored references; zero step counts as single
    function automatic sp_pkg::switch_class_t cls_of(input logic [6:0] a, input logic [6:0] b);
        int d;
        d = int'(a[5:0]) - int'(b[5:0]);
        if (a[6] != b[6]) return sp_pkg::CLASS_RANGE;
        if (d <= 1 && d >= -1) return sp_pkg::CLASS_SINGLE;
        return sp_pkg::CLASS_MULTI;
    endfunction : cls_of

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int                    k, cnt, r, ncyc;
        logic [5:0]            s;
        logic [6:0]            nv;
        sp_pkg::switch_class_t ec;
        logic [1:0]            seen, ex;
        logic                  ln;
        seed = 46127;
        mrw = '0;
        {rstn, go0, go1, lvl, op, acc, seen} = '0;
        cref = '{sp_pkg::CMD_REF_RESET, sp_pkg::CMD_REF_RESET};
        lat = '{sp_pkg::LATENCY_RESET, sp_pkg::LATENCY_RESET};
        // One burst per lane during reset: the capture flops have no reset
        @(posedge ref_clk);
        #1;
        {go0, go1} = 2'b11;
        @(posedge ref_clk);
        #1;
        {go0, go1} = 2'b00;
        repeat (6) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        chk(active_point === 1'b0 && operating_point_select === 1'b0, "reset point");
        chk(active_cmd_ref === sp_pkg::CMD_REF_RESET && wl_active === 1'b0, "reset set");
        chk(switch_class === sp_pkg::CLASS_NONE && dq_oe === 16'h0000, "reset misc");
        // Six switches, alternating direction, through each class twice
        for (k = 0; k < 6; k++) begin
            r = $random(seed);
            s = cref[op][5:0];
            case (k % 3)
                0: nv = {cref[op][6], (s < 6'h3F) ? s + 6'h01 : s - 6'h01};
                1: nv = {cref[op][6], (s < 6'h30) ? s + 6'h02 + 6'(r[2:0]) : s - 6'h02 - 6'(r[2:0])};
                default: nv = {~cref[op][6], r[8:3]};
            endcase
            pc_wr(op, ~op, 1'b0);
            mrw_wr(sp_pkg::REG_COMMAND_REFERENCE, {1'b0, nv});
            mrw_wr(sp_pkg::REG_LATENCY, {1'b0, r[15:9]});
            mrw_wr(sp_pkg::REG_OTHER, r[23:16]);
            ec = cls_of(cref[0], cref[1]);
            ncyc = (ec == sp_pkg::CLASS_RANGE) ? int'(sp_pkg::RANGE_CYC) :
                   (ec == sp_pkg::CLASS_MULTI) ? int'(sp_pkg::MULTI_CYC) : int'(sp_pkg::SINGLE_CYC);
            op = ~op;
            pc_wr(op, acc, 1'b1);
            cnt = 0;
            repeat (32) begin
                if (switch_busy === 1'b1) cnt++;
                @(posedge ref_clk);
                #1;
            end
            chk(cnt === ncyc, "switch time");
            chk(switch_class === ec, "switch class");
            chk(active_point === op && operating_point_select === op, "active point");
            chk(active_cmd_ref === cref[op] && active_latency === lat[op], "active set");
            chk(reference_current_mode === 1'b1 && point_access_select === acc, "point bits");
            pc_wr(op, acc, 1'b0);
            chk(reference_current_mode === 1'b0, "current mode back");
        end
        // Write leveling: enter, wait, random lane bursts, exit
        mrw_wr(sp_pkg::REG_LATENCY, {1'b1, lat[acc]});
        chk(wl_active === 1'b1, "leveling on");
        @(posedge ref_clk);
        #1;
        chk(dq_oe === 16'hFFFF, "leveling drive");
        repeat (40) @(posedge ref_clk);
        for (k = 0; k < 10; k++) begin
            r = $random(seed);
            ln = (k < 2) ? k[0] : r[0];
            lvl = r[1];
            ex[ln] = r[1];
            seen[ln] = 1'b1;
            if (ln) go1 = 1'b1;
            else go0 = 1'b1;
            @(posedge ref_clk);
            #1;
            {go0, go1} = 2'b00;
            repeat (40) @(posedge ref_clk);
            #1;
            chk(dq_out[8*ln +: 8] === {8{ex[ln]}}, "lane level");
            if (seen[!ln]) chk(dq_out[8*(!ln) +: 8] === {8{ex[!ln]}}, "other lane");
        end
        mrw_wr(sp_pkg::REG_LATENCY, {1'b0, lat[acc]});
        repeat (2) @(posedge ref_clk);
        #1;
        chk(wl_active === 1'b0 && dq_oe === 16'h0000 && dq_out === 16'h0000, "leveling off");
        complete_run();
    end
endmodule : set_point_switch_and_write_leveling_tb

`default_nettype wire
